// file: verilog/motion_cmd_core.sv
// Initialization and interrupt command decoder with APB register access
`timescale 1ns/1ps
module motion_cmd_core
  import motion_cmd_pkg::*;
#(
  parameter int BUSY_CYCLES = BUSY_CYC
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Encoder pins
  input wire logic ENC_A,
  input wire logic ENC_B,
  input wire logic ENC_INDEX,
  // Motion logic on the same clock
  input wire logic [31:0] ABS_POS,
  input wire logic [31:0] TARGET_POS,
  input wire logic [15:0] POS_ERR,
  input wire logic [15:0] MOTOR_IN,
  input wire logic WRAP_EVT,
  input wire logic TRAJ_DONE,
  // Outputs
  output logic [11:0] DAC_OUT,
  output logic WIDE_OUT,
  output logic MOTOR_HOLD,
  output logic PARAM_CLEAR,
  output logic HOME_SET,
  output logic HOST_IRQ
);

  // Refuse busy lengths that the eight-bit counter cannot hold
  if (BUSY_CYCLES < 1 || BUSY_CYCLES > 255)
  begin : busy_range_check
    $error("BUSY_CYCLES must lie in 1..255");
  end

  typedef struct packed {
    ctl_state_type st;
    logic [7:0] cmd;
    logic [1:0] words;
    logic [7:0] busy;
    logic [15:0] rcnt;
    logic wide;
    logic stop_en;
    logic stop_hold;
    logic [5:0] mask;
    logic [5:0] flags;
    logic armed;
    logic idx_seen;
    logic [31:0] idx_pos;
    logic [14:0] thresh;
    logic [15:0] hi_word;
    logic [31:0] bp;
    logic bp_en;
    logic [11:0] dac;
    logic clr;
    logic home;
    logic irq;
    logic [1:0] a_sy;
    logic [1:0] b_sy;
    logic [1:0] i_sy;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } core_type;

  core_type q;
  core_type d;

  word_pair_if w ();

  logic xfer;
  logic acc;
  logic wr_cmd;
  logic wr_data;
  logic busy;
  logic take_cmd;
  logic take_data;
  logic [15:0] err_abs;
  logic [7:0] status;
  logic idx_low;

  // Bus decode and acceptance
  assign acc = PSEL & PENABLE & ~q.pready;
  assign xfer = PSEL & PENABLE & q.pready;
  assign wr_cmd = xfer & PWRITE & (PADDR == CMD_OFS);
  assign wr_data = xfer & PWRITE & (PADDR == DATA_OFS);
  assign busy = (q.busy != 8'h00) | (q.st == ST_RESET);
  assign take_cmd = wr_cmd & (~busy | (PWDATA[7:0] == CMD_RESET));
  assign take_data = wr_data & ~busy & (q.st == ST_DATA);
  assign err_abs = POS_ERR[15] ? 16'(-POS_ERR) : POS_ERR;
  assign status = {1'b0, q.flags, busy};
  assign idx_low = ~q.a_sy[1] & ~q.b_sy[1] & ~q.i_sy[1];

  // Feed data bytes to the pairer
  assign w.byte_valid = take_data;
  assign w.byte_data = PWDATA[7:0];
  assign w.restart = take_cmd;

  word_pairer pairer_inst (
    .clk(CLK),
    .nrst(NRST),
    .w(w)
  );

  // Next state of the whole decoder
  always_comb
  begin
    d = q;
    d.clr = 1'b0;
    d.home = 1'b0;
    d.pready = acc;
    d.pslverr = 1'b0;
    // Pin synchronisers
    d.a_sy = {q.a_sy[0], ENC_A};
    d.b_sy = {q.b_sy[0], ENC_B};
    d.i_sy = {q.i_sy[0], ENC_INDEX};

    // Read data and error answer, captured in the first access cycle
    if (acc)
    begin
      d.prdata = 32'h0000_0000;
      if (PADDR == STATUS_OFS)
        d.prdata = {24'h00_0000, status};
      else if (PADDR == MASK_OFS)
        d.prdata = {25'h000_0000, q.mask, 1'b0};
      else if (PADDR == INDEX_OFS)
        d.prdata = q.idx_pos;
      else if (PADDR == CTRL_OFS)
        d.prdata = {29'h0000_0000, q.stop_hold, q.stop_en, q.wide};
      else if (PADDR == CMD_OFS || PADDR == DATA_OFS)
        d.prdata = 32'h0000_0000;
      else
        d.pslverr = 1'b1;
    end

    // Busy countdown; a completed word raises busy again
    if (q.busy != 8'h00)
      d.busy = q.busy - 8'h01;
    if (take_data & w.hi_have)
      d.busy = 8'(BUSY_CYCLES);

    // Motor output: zero code while held, else top bits offset binary
    if (q.stop_hold)
      d.dac = q.wide ? DAC_ZERO_WIDE : DAC_ZERO_NARROW;
    else if (q.wide)
      d.dac = MOTOR_IN[15:4] ^ DAC_ZERO_WIDE;
    else
      d.dac = {4'h0, MOTOR_IN[15:8] ^ 8'h80};

    // Reset sequence, hardware or command
    if (q.st == ST_RESET)
    begin
      if (q.rcnt == 16'h0000)
      begin
        d.clr = 1'b1;
        d.home = 1'b1;
      end
      d.mask = MASK_RESET;
      d.wide = 1'b0;
      d.stop_en = 1'b0;
      d.stop_hold = 1'b0;
      d.bp_en = 1'b0;
      d.armed = 1'b0;
      d.dac = (q.rcnt < 16'(RESET_WIDE_CYC)) ? DAC_ZERO_WIDE : DAC_ZERO_NARROW;
      d.rcnt = q.rcnt + 16'h0001;
      if (q.rcnt == 16'(RESET_TOTAL_CYC - 1))
        d.st = ST_IDLE;
    end

    // Assembled data word
    if (w.word_valid && q.st == ST_DATA)
    begin
      d.words = q.words - 2'd1;
      if (q.words == 2'd1)
        d.st = ST_IDLE;
      if (q.cmd == CMD_ERROR_THRESHOLD_FLAG || q.cmd == CMD_ERROR_THRESHOLD_STOP)
      begin
        d.thresh = w.word_data[14:0] & THRESH_MAX;
        d.stop_en = (q.cmd == CMD_ERROR_THRESHOLD_STOP);
      end
      else if (q.cmd == CMD_INTERRUPT_MASK)
        d.mask = w.word_data[6:1];
      else if (q.cmd == CMD_INTERRUPT_CLEAR)
        d.flags = q.flags & w.word_data[6:1];
      else if (q.words == 2'd2)
        d.hi_word = w.word_data;
      else if (q.cmd == CMD_BREAKPOINT_ABSOLUTE)
      begin
        d.bp = {q.hi_word, w.word_data};
        d.bp_en = 1'b1;
      end
      else
      begin
        d.bp = TARGET_POS + {q.hi_word, w.word_data};
        d.bp_en = 1'b1;
      end
    end

    // Index capture after arming
    if (q.armed)
    begin
      if (q.i_sy[1])
        d.idx_seen = 1'b1;
      if (q.idx_seen && idx_low)
      begin
        d.idx_pos = ABS_POS;
        d.flags[FLAG_INDEX] = 1'b1;
        d.armed = 1'b0;
      end
    end

    // Conditions set flags after any clear, so a set wins
    if (err_abs > {1'b0, q.thresh})
    begin
      d.flags[FLAG_POS_ERR] = 1'b1;
      if (q.stop_en)
        d.stop_hold = 1'b1;
    end
    if (q.bp_en && ABS_POS == q.bp)
    begin
      d.flags[FLAG_BREAK] = 1'b1;
      d.bp_en = 1'b0;
    end
    if (WRAP_EVT)
      d.flags[FLAG_WRAP] = 1'b1;
    if (TRAJ_DONE)
      d.flags[FLAG_TRAJ] = 1'b1;

    // Command byte
    if (take_cmd)
    begin
      d.cmd = PWDATA[7:0];
      d.busy = 8'(BUSY_CYCLES);
      d.st = ST_IDLE;
      d.words = 2'd0;
      if (PWDATA[7:0] == CMD_RESET)
      begin
        d.st = ST_RESET;
        d.rcnt = 16'h0000;
      end
      else if (PWDATA[7:0] == CMD_SELECT_NARROW_OUTPUT)
        d.wide = 1'b0;
      else if (PWDATA[7:0] == CMD_SELECT_WIDE_OUTPUT)
        d.wide = 1'b1;
      else if (PWDATA[7:0] == CMD_DEFINE_HOME)
        d.home = 1'b1;
      else if (PWDATA[7:0] == CMD_ARM_INDEX_CAPTURE)
      begin
        d.armed = 1'b1;
        d.idx_seen = 1'b0;
      end
      else if (PWDATA[7:0] == CMD_ERROR_THRESHOLD_FLAG
        || PWDATA[7:0] == CMD_ERROR_THRESHOLD_STOP
        || PWDATA[7:0] == CMD_INTERRUPT_MASK
        || PWDATA[7:0] == CMD_INTERRUPT_CLEAR)
      begin
        d.st = ST_DATA;
        d.words = 2'd1;
      end
      else if (PWDATA[7:0] == CMD_BREAKPOINT_ABSOLUTE
        || PWDATA[7:0] == CMD_BREAKPOINT_RELATIVE)
      begin
        d.st = ST_DATA;
        d.words = 2'd2;
      end
      else if (PWDATA[7:0] == CMD_START_MOTION)
        d.stop_hold = 1'b0;
      else if (PWDATA[7:0] == CMD_UPDATE_FILTER
        || PWDATA[7:0] == CMD_LOAD_FILTER
        || PWDATA[7:0] == CMD_LOAD_TRAJECTORY
        || (PWDATA[7:0] >= CMD_REPORT_FIRST && PWDATA[7:0] <= CMD_REPORT_LAST))
        d.st = ST_IDLE;
      else
        d.flags[FLAG_CMD_ERR] = 1'b1;
    end

    // Interrupt output, gated by mask
    d.irq = |(q.flags & q.mask);
  end

  // State register
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      q <= '0;
      q.st <= ST_RESET;
      q.dac <= DAC_ZERO_WIDE;
      q.mask <= MASK_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign PRDATA = q.prdata;
  assign PREADY = q.pready;
  assign PSLVERR = q.pslverr;
  assign DAC_OUT = q.dac;
  assign WIDE_OUT = q.wide;
  assign MOTOR_HOLD = q.stop_hold;
  assign PARAM_CLEAR = q.clr;
  assign HOME_SET = q.home;
  assign HOST_IRQ = q.irq;

  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);

  busy_after_cmd_a: assert property (take_cmd |=> busy && q.cmd == $past(PWDATA[7:0]))
    else $error("busy not raised after command");
  cmd_ignored_a: assert property (wr_cmd && busy && PWDATA[7:0] != CMD_RESET
    |=> q.cmd == $past(q.cmd))
    else $error("command taken while busy");
  irq_gate_a: assert property ((|(q.flags & q.mask)) |=> HOST_IRQ)
    else $error("unmasked flag without interrupt");
  irq_quiet_a: assert property (!(|(q.flags & q.mask)) |=> !HOST_IRQ)
    else $error("interrupt for masked flag");
  reset_wide_a: assert property ((q.st == ST_RESET && q.rcnt == 16'h0000)
    |=> (DAC_OUT == DAC_ZERO_WIDE && q.st == ST_RESET)[*8])
    else $error("wide zero code not held during reset");
  reset_narrow_a: assert property ((q.st == ST_RESET && q.rcnt == 16'(RESET_WIDE_CYC))
    |=> DAC_OUT == DAC_ZERO_NARROW)
    else $error("narrow zero code missing after wide phase");
  reset_state_a: assert property ($fell(q.st == ST_RESET)
    |-> q.mask == MASK_RESET && !WIDE_OUT)
    else $error("mask or width wrong after reset");
  reset_bound_a: assert property (q.st == ST_RESET |-> q.rcnt < 16'(RESET_TOTAL_CYC))
    else $error("reset runs too long");
  narrow_cmd_a: assert property (take_cmd && PWDATA[7:0] == CMD_SELECT_NARROW_OUTPUT
    |=> !WIDE_OUT)
    else $error("narrow width not selected");
  index_cap_a: assert property (q.armed && q.idx_seen && idx_low && q.st != ST_RESET
    |=> q.flags[FLAG_INDEX] && q.idx_pos == $past(ABS_POS) && !q.armed)
    else $error("index position not captured");
  thresh_flag_a: assert property (err_abs > {1'b0, q.thresh} |=> q.flags[FLAG_POS_ERR])
    else $error("position error flag not set");
  stop_zero_a: assert property (q.stop_hold && q.st != ST_RESET && !take_cmd
    |=> DAC_OUT == ($past(q.wide) ? DAC_ZERO_WIDE : DAC_ZERO_NARROW))
    else $error("held motor output not at zero code");
  bp_hit_a: assert property (q.bp_en && ABS_POS == q.bp && q.st != ST_DATA
    |=> q.flags[FLAG_BREAK] && !q.bp_en)
    else $error("breakpoint not flagged");
  sticky_a: assert property (q.flags[FLAG_BREAK]
    && !(w.word_valid && q.cmd == CMD_INTERRUPT_CLEAR) |=> q.flags[FLAG_BREAK])
    else $error("breakpoint flag dropped without clear");

endmodule

// file: verilog/motion_cmd_pkg.sv
// Shared constants and types for the motion controller command decoder
package motion_cmd_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] DATA_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] MASK_OFS = 8'h0c;
  localparam logic [7:0] INDEX_OFS = 8'h10;
  localparam logic [7:0] CTRL_OFS = 8'h14;

  // Command codes
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] CMD_START_MOTION = 8'h01;
  localparam logic [7:0] CMD_DEFINE_HOME = 8'h02;
  localparam logic [7:0] CMD_ARM_INDEX_CAPTURE = 8'h03;
  localparam logic [7:0] CMD_UPDATE_FILTER = 8'h04;
  localparam logic [7:0] CMD_SELECT_NARROW_OUTPUT = 8'h05;
  localparam logic [7:0] CMD_SELECT_WIDE_OUTPUT = 8'h06;
  localparam logic [7:0] CMD_REPORT_FIRST = 8'h07;
  localparam logic [7:0] CMD_REPORT_LAST = 8'h0d;
  localparam logic [7:0] CMD_ERROR_THRESHOLD_STOP = 8'h1a;
  localparam logic [7:0] CMD_ERROR_THRESHOLD_FLAG = 8'h1b;
  localparam logic [7:0] CMD_INTERRUPT_MASK = 8'h1c;
  localparam logic [7:0] CMD_INTERRUPT_CLEAR = 8'h1d;
  localparam logic [7:0] CMD_LOAD_FILTER = 8'h1e;
  localparam logic [7:0] CMD_LOAD_TRAJECTORY = 8'h1f;
  localparam logic [7:0] CMD_BREAKPOINT_ABSOLUTE = 8'h20;
  localparam logic [7:0] CMD_BREAKPOINT_RELATIVE = 8'h21;

  // Flag positions inside the six-bit field (status bit = index + 1)
  localparam int FLAG_CMD_ERR = 0;
  localparam int FLAG_TRAJ = 1;
  localparam int FLAG_INDEX = 2;
  localparam int FLAG_WRAP = 3;
  localparam int FLAG_POS_ERR = 4;
  localparam int FLAG_BREAK = 5;

  // Reset values and the threshold limit
  localparam logic [5:0] MASK_RESET = 6'h1f;
  localparam logic [11:0] DAC_ZERO_WIDE = 12'h800;
  localparam logic [11:0] DAC_ZERO_NARROW = 12'h080;
  localparam logic [14:0] THRESH_MAX = 15'h7fff;

  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int BUSY_NS = 20;
  localparam int RESET_WIDE_NS = 1000;
  localparam int RESET_TOTAL_NS = 2000;
  localparam int BUSY_CYC = BUSY_NS / CLK_PERIOD_NS;
  localparam int RESET_WIDE_CYC = (RESET_WIDE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_TOTAL_CYC = RESET_TOTAL_NS / CLK_PERIOD_NS;

  // Decoder states
  typedef enum logic [1:0] {ST_RESET, ST_IDLE, ST_DATA} ctl_state_type;

endpackage

// file: verilog/word_pair_if.sv
// Byte stream in, assembled 16-bit words out
`timescale 1ns/1ps
interface word_pair_if;
  logic byte_valid;
  logic [7:0] byte_data;
  logic restart;
  logic hi_have;
  logic word_valid;
  logic [15:0] word_data;

  modport feeder (output byte_valid, output byte_data, output restart,
    input hi_have, input word_valid, input word_data);
  modport pairer (input byte_valid, input byte_data, input restart,
    output hi_have, output word_valid, output word_data);
endinterface

// file: verilog/word_pairer.sv
// Gathers data bytes in pairs, first byte high
`timescale 1ns/1ps
module word_pairer
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Byte and word carrier
  word_pair_if.pairer w
);

  typedef struct packed {
    logic hi_have;
    logic [7:0] hi;
    logic word_valid;
    logic [15:0] word;
  } pair_type;

  pair_type q;
  pair_type d;

  // Next state: first byte held, second completes the word
  always_comb
  begin
    d = q;
    d.word_valid = 1'b0;
    if (w.restart)
    begin
      d.hi_have = 1'b0;
    end
    else if (w.byte_valid)
    begin
      if (q.hi_have)
      begin
        d.word = {q.hi, w.byte_data};
        d.word_valid = 1'b1;
        d.hi_have = 1'b0;
      end
      else
      begin
        d.hi = w.byte_data;
        d.hi_have = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs to the decoder
  assign w.hi_have = q.hi_have;
  assign w.word_valid = q.word_valid;
  assign w.word_data = q.word;

endmodule

// file: bench/motion_far_model.sv
// Behavioural model of the motion logic and encoder beside the decoder
`timescale 1ns/1ps
module motion_far_model
(
  // Clock
  input wire logic clk,
  // Encoder pins
  output logic enc_a,
  output logic enc_b,
  output logic enc_index,
  // Motion values
  output logic [31:0] abs_pos,
  output logic [31:0] target_pos,
  output logic [15:0] pos_err,
  output logic [15:0] motor_in,
  output logic wrap_evt,
  output logic traj_done
);
  // Quiet values at time zero
  initial
  begin
    {enc_a, enc_b, enc_index, wrap_evt, traj_done} = 5'h00;
    abs_pos = 32'h0;
    target_pos = 32'h0;
    pos_err = 16'h0;
    motor_in = 16'h0;
  end

  // Positions change just after an edge
  task automatic set_pos(input logic [31:0] a, input logic [31:0] t);
    @(posedge clk);
    abs_pos <= a;
    target_pos <= t;
  endtask

  // Loop error and filter output
  task automatic set_err(input logic [15:0] e, input logic [15:0] mi);
    @(posedge clk);
    pos_err <= e;
    motor_in <= mi;
  endtask

  // One-cycle wrap and trajectory events
  task automatic pulse(input logic w, input logic t);
    @(posedge clk);
    wrap_evt <= w;
    traj_done <= t;
    @(posedge clk);
    wrap_evt <= 1'h0;
    traj_done <= 1'h0;
  endtask

  // Index high with both phases high, then all low; position moves to p only then
  task automatic index_pulse(input logic [31:0] p);
    @(posedge clk);
    enc_a <= 1'h1;
    enc_b <= 1'h1;
    enc_index <= 1'h1;
    abs_pos <= p + 32'h7;
    repeat (3) @(posedge clk);
    enc_a <= 1'h0;
    enc_b <= 1'h0;
    enc_index <= 1'h0;
    abs_pos <= p;
    repeat (6) @(posedge clk);
  endtask
endmodule

// file: bench/motion_init_interrupt_cmds_tb.sv
// Self-checking bench for the motion command decoder
`timescale 1ns/1ps
module motion_init_interrupt_cmds_tb;
  import motion_cmd_pkg::*;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, abs_pos, target_pos, rdat, m, bp, thr;
  logic [15:0] pos_err, motor_in;
  logic [11:0] dac_out;
  logic pready, pslverr, enc_a, enc_b, enc_index, wrap_evt, traj_done, rerr;
  logic wide_out, motor_hold, param_clear, home_set, host_irq;
  int num_errors = 0;
  int num_checks = 0;
  int seed = 59;
  int pc_cnt = 0;
  int hs_cnt = 0;
  int i;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // Count the one-cycle clear and home pulses
  always @(posedge clk)
  begin
    if (param_clear === 1'h1) pc_cnt <= pc_cnt + 1;
    if (home_set === 1'h1) hs_cnt <= hs_cnt + 1;
  end

  motion_cmd_core #(.BUSY_CYCLES(8)) u_dut (.CLK(clk), .NRST(nrst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .ENC_A(enc_a), .ENC_B(enc_b), .ENC_INDEX(enc_index),
    .ABS_POS(abs_pos), .TARGET_POS(target_pos), .POS_ERR(pos_err), .MOTOR_IN(motor_in),
    .WRAP_EVT(wrap_evt), .TRAJ_DONE(traj_done), .DAC_OUT(dac_out), .WIDE_OUT(wide_out),
    .MOTOR_HOLD(motor_hold), .PARAM_CLEAR(param_clear), .HOME_SET(home_set),
    .HOST_IRQ(host_irq));

  motion_far_model u_far (.clk(clk), .enc_a(enc_a), .enc_b(enc_b), .enc_index(enc_index),
    .abs_pos(abs_pos), .target_pos(target_pos), .pos_err(pos_err), .motor_in(motor_in),
    .wrap_evt(wrap_evt), .traj_done(traj_done));

  // Verdict and end of run
  task automatic summarize();
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Value comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1)
    begin
      num_errors++;
      summarize();
    end
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'h0, a, 32'h0);
  endtask

  // Poll status until busy is low, bounded
  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      rd(STATUS_OFS);
      n++;
    end while (rdat[0] !== 1'h0 && n < 200);
    if (rdat[0] !== 1'h0)
    begin
      num_errors++;
      summarize();
    end
  endtask

  task automatic cmd(input logic [7:0] c);
    wait_idle();
    apb(1'h1, CMD_OFS, {24'h0, c});
  endtask

  // Data word, high byte first
  task automatic word(input logic [15:0] w);
    wait_idle();
    apb(1'h1, DATA_OFS, {24'h0, w[15:8]});
    apb(1'h1, DATA_OFS, {24'h0, w[7:0]});
  endtask

  task automatic clear_flags();
    cmd(CMD_INTERRUPT_CLEAR);
    word(16'h0000);
    wait_idle();
  endtask

  // Offset-binary converter code from the top bits of the filter output
  function automatic logic [11:0] dac_exp(input logic [15:0] mi, input logic w);
    return w ? {~mi[15], mi[14:4]} : {4'h0, ~mi[15], mi[14:8]};
  endfunction

  // Hang guard
  initial
  begin
    repeat (90000) @(posedge clk);
    num_errors++;
    summarize();
  end

  initial
  begin
    // Hardware reset and its sequence
    repeat (4) @(posedge clk);
    chk(32'(dac_out), 32'(DAC_ZERO_WIDE));
    nrst <= 1'h1;
    repeat (20) @(posedge clk);
    chk(32'(pc_cnt), 32'h1);
    chk(32'(hs_cnt), 32'h1);
    chk(32'(dac_out), 32'(DAC_ZERO_WIDE));
    wait_idle();
    chk(32'(dac_out), 32'(DAC_ZERO_NARROW));
    rd(MASK_OFS);
    chk(rdat, {25'h0, MASK_RESET, 1'h0});
    rd(CTRL_OFS);
    chk(rdat & 32'h1, 32'h0);
    rd(8'h18);
    chk(32'(rerr), 32'h1);
    // Width select, and a command refused while busy
    cmd(CMD_SELECT_WIDE_OUTPUT);
    wait_idle();
    chk(32'(wide_out), 32'h1);
    chk(32'(dac_out), 32'(DAC_ZERO_WIDE));
    cmd(CMD_SELECT_NARROW_OUTPUT);
    apb(1'h1, CMD_OFS, {24'h0, CMD_SELECT_WIDE_OUTPUT});
    rd(STATUS_OFS);
    chk(rdat & 32'h1, 32'h1);
    wait_idle();
    rd(CTRL_OFS);
    chk(rdat & 32'h1, 32'h0);
    chk(32'(dac_out), 32'(DAC_ZERO_NARROW));
    cmd(CMD_DEFINE_HOME);
    repeat (4) @(posedge clk);
    chk(32'(hs_cnt), 32'h2);
    // Codes served by other logic raise no command error
    clear_flags();
    cmd(CMD_UPDATE_FILTER);
    cmd(CMD_LOAD_FILTER);
    cmd(CMD_LOAD_TRAJECTORY);
    cmd(CMD_REPORT_LAST);
    wait_idle();
    rd(STATUS_OFS);
    chk(rdat & 32'h2, 32'h0);
    // Undefined code flags a command error
    clear_flags();
    cmd(8'h30);
    wait_idle();
    rd(STATUS_OFS);
    chk(rdat & 32'h2, 32'h2);
    // Masks with events
    for (i = 0; i < 4; i++)
    begin
      m = $random(seed);
      if (i == 0) m = 32'h0000ff81;
      clear_flags();
      cmd(CMD_INTERRUPT_MASK);
      word(m[15:0]);
      wait_idle();
      rd(MASK_OFS);
      chk(rdat, {25'h0, m[6:1], 1'h0});
      u_far.pulse(1'h1, 1'h1);
      rd(STATUS_OFS);
      chk(rdat & 32'h14, 32'h14);
      chk(32'(host_irq), 32'(m[4] | m[2]));
    end
    // Error threshold, flag only
    thr = $random(seed) & 32'h7ffe;
    cmd(CMD_ERROR_THRESHOLD_FLAG);
    word(thr[15:0]);
    u_far.set_err(thr[15:0], 16'h4000);
    clear_flags();
    rd(STATUS_OFS);
    chk(rdat & 32'h20, 32'h0);
    chk(32'(dac_out), 32'(dac_exp(16'h4000, 1'h0)));
    u_far.set_err(16'h0 - thr[15:0] - 16'h1, 16'h4000);
    rd(STATUS_OFS);
    chk(rdat & 32'h20, 32'h20);
    u_far.set_err(16'h0, 16'h4000);
    rd(STATUS_OFS);
    chk(rdat & 32'h20, 32'h20);
    // Error threshold with stop
    cmd(CMD_ERROR_THRESHOLD_STOP);
    word(16'h0010);
    wait_idle();
    u_far.set_err(16'h0011, 16'h4000);
    repeat (6) @(posedge clk);
    chk(32'(motor_hold), 32'h1);
    chk(32'(dac_out), 32'(DAC_ZERO_NARROW));
    u_far.set_err(16'h0, 16'h0);
    cmd(CMD_START_MOTION);
    wait_idle();
    chk(32'(motor_hold), 32'h0);
    // Absolute breakpoint stays flagged after passing
    bp = $random(seed) & 32'h0fffffff;
    u_far.set_pos(bp - 32'h5, 32'h0);
    clear_flags();
    cmd(CMD_BREAKPOINT_ABSOLUTE);
    word(bp[31:16]);
    word(bp[15:0]);
    wait_idle();
    rd(STATUS_OFS);
    chk(rdat & 32'h40, 32'h0);
    u_far.set_pos(bp, 32'h0);
    u_far.set_pos(bp + 32'h1, 32'h0);
    rd(STATUS_OFS);
    chk(rdat & 32'h40, 32'h40);
    clear_flags();
    rd(STATUS_OFS);
    chk(rdat & 32'h40, 32'h0);
    // Relative breakpoint, target plus offset kept in range
    u_far.set_pos(32'h100, 32'h1000);
    cmd(CMD_BREAKPOINT_RELATIVE);
    word(16'h0000);
    word(16'h0040);
    wait_idle();
    u_far.set_pos(32'h1040, 32'h1000);
    rd(STATUS_OFS);
    chk(rdat & 32'h40, 32'h40);
    // Index capture on the all-low state
    m = $random(seed);
    clear_flags();
    cmd(CMD_ARM_INDEX_CAPTURE);
    wait_idle();
    u_far.index_pulse(m);
    rd(INDEX_OFS);
    chk(rdat, m);
    rd(STATUS_OFS);
    chk(rdat & 32'h8, 32'h8);
    // Reset command in mid-run
    cmd(CMD_SELECT_WIDE_OUTPUT);
    cmd(CMD_RESET);
    repeat (10) @(posedge clk);
    chk(32'(pc_cnt), 32'h2);
    chk(32'(dac_out), 32'(DAC_ZERO_WIDE));
    wait_idle();
    chk(32'(hs_cnt), 32'h3);
    chk(32'(dac_out), 32'(DAC_ZERO_NARROW));
    rd(MASK_OFS);
    chk(rdat, {25'h0, MASK_RESET, 1'h0});
    rd(CTRL_OFS);
    chk(rdat & 32'h1, 32'h0);
    summarize();
  end
endmodule
